//--- core/lsw_pkg.sv
// constants for the led driver serial control and status word logic
package lsw_pkg;
    // ---------------------------------------------------------------
    // word geometry, zero-based bit positions (bit n is index n-1)
    // ---------------------------------------------------------------
    localparam int WORD_W = 36;
    localparam int ADDR_LSB = 0;
    localparam int ADDR_W = 3;
    localparam int INTA_LSB = 3;
    localparam int INTB_LSB = 13;
    localparam int INT_W = 10;
    localparam int WDDIS_BIT = 23;
    localparam int DIV_LSB = 24;
    localparam int DIV_W = 4;
    localparam int COARSEA_LSB = 28;
    localparam int COARSEB_LSB = 32;
    localparam int COARSE_W = 4;
    localparam int SLOTS = 8;
    // status word
    localparam int OPENA_LSB = 0;
    localparam int OPENB_LSB = 8;
    localparam int WDFLAG_BIT = 16;
    localparam int THERM_BIT = 17;
    localparam int REV_LSB = 18;
    localparam int REV_W = 3;
    localparam int FILL_LSB = 21;
    localparam int FILL_W = 15;
    localparam logic [14:0] FILL_PATTERN = 15'h2AAA;
    // ---------------------------------------------------------------
    // input synchroniser lanes
    // ---------------------------------------------------------------
    localparam int SYNC_W = 20;
    localparam int LANE_SCLK = 0;
    localparam int LANE_LOAD = 1;
    localparam int LANE_SIN = 2;
    localparam int LANE_THERM = 3;
    localparam int LANE_OPEN = 4;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int WD_MIN_US = 25;
    localparam int WD_MAX_US = 200;
    // longest time, rounded down to whole cycles
    localparam int WD_CYCLES = WD_MAX_US * CLK_MHZ;
    localparam logic [2:0] REV_DEFAULT = 3'h5; // arbitrary value

    typedef enum logic [1:0] {
        XF_SHIFT,
        XF_WAIT_FALL,
        XF_WAIT_RISE,
        XF_HOLD
    } lsw_xfer_type;
endpackage

//--- core/lsw_serial_word.sv
// serial control word intake and status word readback for the led driver
`timescale 1ns/1ns
// Contract
// - control word: slot 1-3, intensity A 4-13, B 14-23, wd 24, div, coarse
// - control bit 24 set disables the serial clock watchdog
// - status word: open flags A, B, watchdog, thermal, revision, filler
// - status bits 1-8 report bank A outputs, open output reads 0
// - status bits 9-16 report bank B outputs, same polarity
// - status bit 17 reads 1 after a watchdog timeout
// - status bit 18 reads 1 while over-temperature is detected
// - status bits 22-36 alternate, 0 at even bits, 1 at odd bits
// - timeout after 25 to 200 us without serial clock edges
// - transfer strobe low: plain shift register from input to output
// - strobe high: first falling edge loads control, next rise loads status
// - control bit 36 shifted first, status bit 36 presented first
// - pwm clock is serial clock divided by divisor code plus one
module lsw_serial_word #(
    parameter int WD_CYCLES = lsw_pkg::WD_CYCLES,
    parameter logic [2:0] MASK_REV = lsw_pkg::REV_DEFAULT
) (
    input wire logic clk, // 50 MHz system clock
    input wire logic rst_b, // synchronous reset, active low
    input wire logic serial_bit_clock, // shift clock pin
    input wire logic loadStrobe, // transfer strobe pin
    input wire logic serial_input_pin, // serial data in
    input wire logic overTemp, // over-temperature detect
    input wire logic [7:0] openA, // bank A open detect, 1 = open
    input wire logic [7:0] openB, // bank B open detect, 1 = open
    output logic serialOut, // serial data out
    output logic [79:0] intensityA, // bank A slot intensities
    output logic [79:0] intensityB, // bank B slot intensities
    output logic [3:0] coarseA, // bank A coarse level
    output logic [3:0] coarseB, // bank B coarse level
    output logic [3:0] pwmDivisor, // pwm clock divisor code
    output logic wdDisabled, // watchdog disabled
    output logic pwmTick, // pwm clock enable pulse
    output logic outputsOff // all outputs forced off
);
    localparam int WDW = $clog2(WD_CYCLES + 1);
    localparam int SW = lsw_pkg::SYNC_W;
    localparam int W = lsw_pkg::WORD_W;

    typedef struct packed {
        logic [SW-1:0] s1;
        logic [SW-1:0] s2;
        logic [SW-1:0] s3;
        logic [SW-1:0] filt;
        lsw_pkg::lsw_xfer_type st;
        logic [W-1:0] shift;
        logic [7:0][9:0] intA;
        logic [7:0][9:0] intB;
        logic [3:0] coarseA;
        logic [3:0] coarseB;
        logic [3:0] divisor;
        logic wdDisable;
        logic [WDW-1:0] wdCnt;
        logic wdExpired;
        logic wdFlag;
        logic [3:0] divCnt;
        logic pwmTick;
        logic off;
    } lsw_state_type;

    lsw_state_type r_reg;
    lsw_state_type r_next;
    logic sclkRise;
    logic sclkFall;
    logic loadNow;
    logic sinNow;
    logic thermNow;
    logic [W-1:0] statusWord;

    // ---------------------------------------------------------------
    // status word assembly
    // ---------------------------------------------------------------
    function automatic logic [W-1:0] buildStatus(
        input logic [15:0] openFilt,
        input logic wdf,
        input logic therm
    );
        logic [W-1:0] s;
        s = '0;
        // open output reads 0
        s[lsw_pkg::OPENA_LSB +: 8] = ~openFilt[7:0];
        s[lsw_pkg::OPENB_LSB +: 8] = ~openFilt[15:8];
        s[lsw_pkg::WDFLAG_BIT] = wdf;
        s[lsw_pkg::THERM_BIT] = therm;
        s[lsw_pkg::REV_LSB +: lsw_pkg::REV_W] = MASK_REV;
        s[lsw_pkg::FILL_LSB +: lsw_pkg::FILL_W] = lsw_pkg::FILL_PATTERN;
        return s;
    endfunction

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        logic [SW-1:0] agree;
        logic [2:0] slot;
        agree = '0;
        slot = '0;
        r_next = r_reg;
        // three-stage sync; a change counts when stages two and three agree
        r_next.s1 = {openB, openA, overTemp, serial_input_pin, loadStrobe,
                     serial_bit_clock};
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        agree = ~(r_reg.s2 ^ r_reg.s3);
        r_next.filt = (agree & r_reg.s3) | (~agree & r_reg.filt);
        sclkRise = r_next.filt[lsw_pkg::LANE_SCLK]
                   & ~r_reg.filt[lsw_pkg::LANE_SCLK];
        sclkFall = ~r_next.filt[lsw_pkg::LANE_SCLK]
                   & r_reg.filt[lsw_pkg::LANE_SCLK];
        loadNow = r_next.filt[lsw_pkg::LANE_LOAD];
        sinNow = r_next.filt[lsw_pkg::LANE_SIN];
        thermNow = r_next.filt[lsw_pkg::LANE_THERM];
        statusWord = buildStatus(r_reg.filt[lsw_pkg::LANE_OPEN +: 16],
                                 r_reg.wdFlag, thermNow);
        slot = r_reg.shift[lsw_pkg::ADDR_LSB +: lsw_pkg::ADDR_W];
        r_next.pwmTick = 1'b0;

        // transfer sequencing
        case (r_reg.st)
            lsw_pkg::XF_SHIFT: begin
                if (loadNow) begin
                    r_next.st = lsw_pkg::XF_WAIT_FALL;
                end else if (sclkRise) begin
                    // first bit in travels to the top, out first
                    r_next.shift = {r_reg.shift[W-2:0], sinNow};
                end
            end
            lsw_pkg::XF_WAIT_FALL: begin
                if (!loadNow) begin
                    r_next.st = lsw_pkg::XF_SHIFT;
                end else if (sclkFall) begin
                    // only the addressed slot takes intensities
                    r_next.intA[slot] =
                        r_reg.shift[lsw_pkg::INTA_LSB +: lsw_pkg::INT_W];
                    r_next.intB[slot] =
                        r_reg.shift[lsw_pkg::INTB_LSB +: lsw_pkg::INT_W];
                    r_next.wdDisable = r_reg.shift[lsw_pkg::WDDIS_BIT];
                    r_next.divisor =
                        r_reg.shift[lsw_pkg::DIV_LSB +: lsw_pkg::DIV_W];
                    r_next.coarseA =
                        r_reg.shift[lsw_pkg::COARSEA_LSB +: lsw_pkg::COARSE_W];
                    r_next.coarseB =
                        r_reg.shift[lsw_pkg::COARSEB_LSB +: lsw_pkg::COARSE_W];
                    r_next.st = lsw_pkg::XF_WAIT_RISE;
                end
            end
            lsw_pkg::XF_WAIT_RISE: begin
                if (!loadNow) begin
                    r_next.st = lsw_pkg::XF_SHIFT;
                end else if (sclkRise) begin
                    r_next.shift = statusWord;
                    r_next.st = lsw_pkg::XF_HOLD;
                end
            end
            lsw_pkg::XF_HOLD: begin
                if (!loadNow) begin
                    r_next.st = lsw_pkg::XF_SHIFT;
                end
            end
            default: begin
                r_next.st = lsw_pkg::XF_SHIFT;
            end
        endcase

        // pwm clock divider on serial clock rising edges
        if (sclkRise) begin
            if (r_reg.divCnt >= r_reg.divisor) begin
                r_next.divCnt = '0;
                r_next.pwmTick = 1'b1;
            end else begin
                r_next.divCnt = r_reg.divCnt + 4'h1;
            end
        end

        // watchdog on serial clock activity
        if (r_reg.wdDisable || sclkRise || sclkFall) begin
            r_next.wdCnt = '0;
            r_next.wdExpired = 1'b0;
        end else if (r_reg.wdCnt == WDW'(WD_CYCLES - 1)) begin
            r_next.wdExpired = 1'b1;
        end else begin
            r_next.wdCnt = r_reg.wdCnt + WDW'(1);
        end
        // sticky flag cleared by status capture, a new timeout wins
        if (r_reg.st == lsw_pkg::XF_WAIT_RISE && loadNow && sclkRise) begin
            r_next.wdFlag = 1'b0;
        end
        if (r_next.wdExpired) begin
            r_next.wdFlag = 1'b1;
        end
        r_next.off = r_next.wdExpired | thermNow;
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // outputs straight from flops
    assign serialOut = r_reg.shift[W-1];
    assign intensityA = r_reg.intA;
    assign intensityB = r_reg.intB;
    assign coarseA = r_reg.coarseA;
    assign coarseB = r_reg.coarseB;
    assign pwmDivisor = r_reg.divisor;
    assign wdDisabled = r_reg.wdDisable;
    assign pwmTick = r_reg.pwmTick;
    assign outputsOff = r_reg.off;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    shift_in_a: assert property (
        r_reg.st == lsw_pkg::XF_SHIFT && !loadNow && sclkRise
        |=> r_reg.shift == $past({r_reg.shift[W-2:0], sinNow}))
        else $error("shift register did not shift");
    ctrl_xfer_a: assert property (
        r_reg.st == lsw_pkg::XF_WAIT_FALL && loadNow && sclkFall
        |=> r_reg.divisor == $past(r_reg.shift[27:24])
            && r_reg.coarseB == $past(r_reg.shift[35:32]))
        else $error("control fields not transferred");
    slot_select_a: assert property (
        r_reg.st == lsw_pkg::XF_WAIT_FALL && loadNow && sclkFall
        |=> r_reg.intA[$past(r_reg.shift[2:0])] == $past(r_reg.shift[12:3]))
        else $error("selected slot not updated");
    status_load_a: assert property (
        r_reg.st == lsw_pkg::XF_WAIT_RISE && loadNow && sclkRise
        |=> r_reg.shift[35:21] == 15'h2AAA && serialOut == 1'b0)
        else $error("status filler wrong");
    status_flags_a: assert property (
        r_reg.st == lsw_pkg::XF_WAIT_RISE && loadNow && sclkRise
        |=> r_reg.shift[15:0] == ~$past(r_reg.filt[19:4]))
        else $error("open flags wrong");
    wd_timeout_a: assert property (
        !r_reg.wdDisable && !sclkRise && !sclkFall
        && r_reg.wdCnt == WDW'(WD_CYCLES - 1)
        |=> r_reg.wdExpired && r_reg.off && r_reg.wdFlag)
        else $error("watchdog did not expire");
    wd_disable_a: assert property (
        r_reg.wdDisable |=> !r_reg.wdExpired && r_reg.wdCnt == '0)
        else $error("disabled watchdog still running");
    pwm_tick_a: assert property (
        pwmTick |-> $past(sclkRise) && r_reg.divCnt == '0)
        else $error("pwm tick without clock edge");
    hold_shift_a: assert property (
        r_reg.st == lsw_pkg::XF_HOLD && loadNow
        |=> $stable(r_reg.shift))
        else $error("shift moved while strobe held");
    fall_wait_a: assert property (
        r_reg.st == lsw_pkg::XF_WAIT_FALL |=> $stable(r_reg.shift))
        else $error("shift moved before transfer fall");
    strobe_drop_a: assert property (
        r_reg.st != lsw_pkg::XF_SHIFT && !loadNow
        |=> r_reg.st == lsw_pkg::XF_SHIFT)
        else $error("shift mode not resumed after strobe low");

    // control fields move only on a transfer
    ctrl_rest_a: assert property (
        r_reg.st == lsw_pkg::XF_WAIT_FALL && loadNow && sclkFall
        |=> r_reg.wdDisable == $past(r_reg.shift[23])
            && r_reg.coarseA == $past(r_reg.shift[31:28])
            && r_reg.intB[$past(r_reg.shift[2:0])]
               == $past(r_reg.shift[22:13]))
        else $error("control fields not transferred");
    ctrl_keep_a: assert property (
        !(r_reg.st == lsw_pkg::XF_WAIT_FALL && loadNow && sclkFall)
        |=> $stable(r_reg.divisor) && $stable(r_reg.coarseA)
            && $stable(r_reg.coarseB) && $stable(r_reg.wdDisable))
        else $error("control fields moved without transfer");

    // only the addressed slot may change on a transfer
    for (genvar g = 0; g < lsw_pkg::SLOTS; g++) begin : gSlot
        slot_keep_a: assert property (
            r_reg.shift[lsw_pkg::ADDR_LSB +: lsw_pkg::ADDR_W] != 3'(g)
            |=> $stable(r_reg.intA[g]) && $stable(r_reg.intB[g]))
            else $error("unaddressed slot changed");
    end

    // status capture of flags and revision
    status_fields_a: assert property (
        r_reg.st == lsw_pkg::XF_WAIT_RISE && loadNow && sclkRise
        |=> r_reg.shift[20:18] == MASK_REV
            && r_reg.shift[16] == $past(r_reg.wdFlag)
            && r_reg.shift[17] == $past(thermNow))
        else $error("status flags or revision wrong");

    // watchdog flag and shutdown
    wd_quiet_a: assert property (
        r_reg.wdCnt < WDW'(WD_CYCLES - 1) && !r_reg.wdExpired
        |=> !r_reg.wdExpired)
        else $error("watchdog expired early");
    wd_flag_hold_a: assert property (
        r_reg.wdFlag && !(r_reg.st == lsw_pkg::XF_WAIT_RISE && loadNow
        && sclkRise) |=> r_reg.wdFlag)
        else $error("watchdog flag lost");
    wd_flag_clear_a: assert property (
        r_reg.st == lsw_pkg::XF_WAIT_RISE && loadNow && sclkRise
        && !r_next.wdExpired |=> !r_reg.wdFlag)
        else $error("watchdog flag not cleared by status load");
    therm_off_a: assert property (
        thermNow |=> outputsOff)
        else $error("outputs not forced off when hot");

    // pwm pulse only when the divider wraps
    pwm_gap_a: assert property (
        !(sclkRise && r_reg.divCnt >= r_reg.divisor) |=> !pwmTick)
        else $error("pwm tick too early");
endmodule

//--- testbench/lsw_ctrl_model.sv
// display controller model driving the serial word pins
`timescale 1ns/1ns
module lsw_ctrl_model (
    input wire logic clk, // system clock, paces the pins
    input wire logic serialOut, // device serial data out
    output logic sclkPin, // serial bit clock
    output logic loadPin, // transfer strobe
    output logic dataPin // serial data to device
);
    initial begin
        sclkPin = 1'h0;
        loadPin = 1'h0;
        dataPin = 1'h0;
    end

    // one serial clock phase, six system clocks
    task automatic half();
        repeat (6) @(negedge clk);
    endtask

    // ---------------------------------------------------------------
    // shift one word in, read one word out, then transfer
    // ---------------------------------------------------------------
    task automatic xfer(input logic [35:0] wr, output logic [35:0] rd);
        for (int i = 35; i >= 0; i--) begin
            dataPin = wr[i];
            half();
            rd[i] = serialOut;
            sclkPin = 1'h1;
            half();
            sclkPin = 1'h0;
        end
        dataPin = ~dataPin; // released line shows no stale bit
        loadPin = 1'h1;
        half();
        sclkPin = 1'h1;
        half();
        sclkPin = 1'h0; // fall copies control word
        half();
        sclkPin = 1'h1; // rise loads status word
        half();
        sclkPin = 1'h0;
        half();
        loadPin = 1'h0;
        half();
    endtask
endmodule

//--- testbench/led_driver_serial_word_interface_test.sv
// self-checking bench for the serial control and status word logic
`timescale 1ns/1ns
module led_driver_serial_word_interface_test;
    localparam int WD = 400;
    logic clk, rst_b, overTemp, sclk, load, sdi, serialOut;
    logic [7:0] openA, openB;
    logic [79:0] intensityA, intensityB, expA, expB;
    logic [3:0] coarseA, coarseB, pwmDivisor, prevDiv;
    logic wdDisabled, pwmTick, outputsOff, wdSeen, haveStat;
    logic [35:0] w, rd, eStat;
    int fail_count, cmp_count, cyc, ticks, lo, hi;

    lsw_serial_word #(.WD_CYCLES(WD), .MASK_REV(3'h3)) dut (
        .clk(clk), .rst_b(rst_b), .serial_bit_clock(sclk),
        .loadStrobe(load), .serial_input_pin(sdi), .overTemp(overTemp),
        .openA(openA), .openB(openB), .serialOut(serialOut),
        .intensityA(intensityA), .intensityB(intensityB),
        .coarseA(coarseA), .coarseB(coarseB), .pwmDivisor(pwmDivisor),
        .wdDisabled(wdDisabled), .pwmTick(pwmTick), .outputsOff(outputsOff)
    );
    lsw_ctrl_model ctl (.clk(clk), .serialOut(serialOut), .sclkPin(sclk),
        .loadPin(load), .dataPin(sdi));

    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    // cycle ceiling and pwm pulse count, sampled mid-cycle
    always @(negedge clk) begin
        cyc++;
        if (pwmTick === 1'h1) ticks++;
        if (cyc == 60000) begin
            fail_count++;
            wrap_up();
        end
    end

    // expected status word from pin values
    function automatic logic [35:0] status(logic [7:0] a, b, logic f, t);
        logic [35:0] s;
        s = '0;
        for (int n = 22; n <= 36; n++) s[n - 1] = n[0];
        s[7:0] = ~a;
        s[15:8] = ~b;
        s[16] = f;
        s[17] = t;
        s[20:18] = 3'h3;
        return s;
    endfunction

    task automatic check(input logic [79:0] seen, exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    // one exchange with random pins, then all control outputs compared
    task automatic send(input logic [35:0] word);
        openA = 8'($urandom);
        openB = 8'($urandom);
        overTemp = 1'($urandom);
        ticks = 0;
        ctl.xfer(word, rd);
        if (haveStat) check(rd, eStat, "status word");
        // 37 rises use the old ratio, the status rise the new one
        lo = 37 / (prevDiv + 1);
        hi = (37 + prevDiv) / (prevDiv + 1) + 1;
        check(ticks >= lo && ticks <= hi, 1'h1, "pwm ticks");
        expA[word[2:0] * 10 +: 10] = word[12:3];
        expB[word[2:0] * 10 +: 10] = word[22:13];
        check(intensityA, expA, "intensity A");
        check(intensityB, expB, "intensity B");
        check(pwmDivisor, word[27:24], "divisor");
        check(coarseA, word[31:28], "coarse A");
        check(coarseB, word[35:32], "coarse B");
        check(wdDisabled, word[23], "wd control");
        check(outputsOff, overTemp, "outputs off");
        eStat = status(openA, openB, wdSeen, overTemp);
        wdSeen = 1'h0;
        haveStat = 1'h1;
        prevDiv = word[27:24];
    endtask

    // idle the serial clock and look at the shutdown output
    task automatic idle(input logic exp);
        repeat (WD - 20) @(negedge clk);
        check(outputsOff, overTemp, "early timeout");
        repeat (40) @(negedge clk);
        check(outputsOff, exp | overTemp, "timeout");
        wdSeen = exp;
    endtask

    initial begin
        rst_b = 1'h0;
        overTemp = 1'h0;
        openA = 8'h00;
        openB = 8'h00;
        expA = '0;
        expB = '0;
        prevDiv = 4'h0;
        wdSeen = 1'h0;
        haveStat = 1'h0;
        void'($urandom(32'hFA48));
        repeat (8) @(negedge clk);
        check(intensityA | intensityB, 80'h0, "reset intensity");
        check({pwmDivisor, wdDisabled, outputsOff}, 80'h0, "reset ctl");
        $display("test reset done");
        rst_b = 1'h1;
        repeat (8) @(negedge clk);
        for (int k = 0; k < 16; k++) begin
            w = {4'($urandom), 32'($urandom)};
            w[27:24] = 4'(k);
            w[2:0] = 3'(k);
            w[23] = 1'h1;
            send(w);
        end
        $display("test codes and slots done");
        idle(1'h0);
        send({4'($urandom), 32'($urandom)} & 36'hFFF7FFFFF);
        idle(1'h1);
        for (int k = 0; k < 3; k++) begin
            send({4'($urandom), 32'($urandom)} | 36'h000800000);
        end
        $display("test watchdog done");
        wrap_up();
    end

    task automatic wrap_up();
        $display("compares %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
endmodule
